// File: raw_color_12bit_packer.sv
// Packs raw 12-bit colour filter pixels, two per three bytes
//
// Behaviour
// - Each pixel is 12 bits and every pixel pair becomes three bytes.
// - Pixel values pass unchanged, each site gives only its own sample.
// - Pair packing restarts at a fresh first byte on every row.
// - Byte one of a group holds bits 11..4 of the even-index pixel.
// - Byte two holds odd pixel bits 3..0 high, even pixel bits 3..0 low.
// - Byte three of a group holds bits 11..4 of the odd-index pixel.
// - Even rows alternate blue then green sites.
// - Odd rows alternate green then red sites.
// - Groups repeat to row end; last byte is last pixel 11..4, or pad 0x00 on odd-length rows.
// - Pixels are unsigned 12-bit codes, 0x000 zero, 0xfff full scale.
`timescale 1ns/1ps
module raw_color_12bit_packer #(
    parameter int unsigned FIFO_WORDS = raw_pack_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input raw_pack_pkg::pix_beat_t pix_in,
    input wire logic pix_valid,
    output logic pix_ready,
    output raw_pack_pkg::byte_beat_t byte_out,
    output logic byte_valid,
    input wire logic byte_ready,
    output logic odd_row_error
);
    import raw_pack_pkg::*;

    initial begin
        if (FIFO_WORDS < 4) begin
            $error("raw_color_12bit_packer: FIFO_WORDS below 4");
        end
    end

    // Emitter states: idle/collect, then the three bytes of a group
    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_BYTE0 = 2'b01,
        ST_BYTE1 = 2'b10,
        ST_BYTE2 = 2'b11
    } state_t;

    state_t state_q, state_d;
    logic [11:0] even_q;
    logic [11:0] odd_q;
    logic have_even_q;
    logic row_odd_q;
    logic row_open_q;
    logic group_first_q;
    logic group_last_q;
    logic err_q;
    site_t even_site;
    site_t odd_site;

    site_mapper u_even_site (
        .odd_row(row_odd_q),
        .odd_pix(1'b0),
        .site(even_site)
    );
    site_mapper u_odd_site (
        .odd_row(row_odd_q),
        .odd_pix(1'b1),
        .site(odd_site)
    );

    // FIFO write side
    byte_beat_t fifo_in;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [BYTE_BEAT_W-1:0] fifo_out_raw;

    // Pixel accepted only while collecting; emitting stalls the source
    wire in_fire = pix_valid && pix_ready;
    wire row_begin = in_fire && pix_in.row_start;
    wire pair_done = in_fire && (have_even_q && !row_begin);
    wire lone_end = in_fire && pix_in.row_end && !pair_done;
    wire byte_fire = fifo_in_valid && fifo_in_ready;
    wire is_collect = (state_q == ST_COLLECT);
    assign pix_ready = is_collect;

    // Byte selection per group position, values untouched
    wire [7:0] b0 = even_q[HI_MSB:HI_LSB];
    wire [7:0] b1 = {odd_q[LO_MSB:0], even_q[LO_MSB:0]};
    wire [7:0] b2 = odd_q[HI_MSB:HI_LSB];

    always_comb begin
        fifo_in = '0;
        fifo_in_valid = 1'b0;
        unique case (state_q)
            ST_COLLECT: begin
                fifo_in_valid = 1'b0;
            end
            ST_BYTE0: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = b0;
                fifo_in.row_first = group_first_q;
                fifo_in.site = even_site;
            end
            ST_BYTE1: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = b1;
                fifo_in.site = odd_site;
            end
            ST_BYTE2: begin
                fifo_in_valid = 1'b1;
                fifo_in.data = b2;
                fifo_in.row_last = group_last_q;
                fifo_in.site = odd_site;
            end
        endcase
    end

    // Next state of the group emitter
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_COLLECT: begin
                if (pair_done || lone_end) begin
                    state_d = ST_BYTE0;
                end
            end
            ST_BYTE0: begin
                if (byte_fire) begin
                    state_d = ST_BYTE1;
                end
            end
            ST_BYTE1: begin
                if (byte_fire) begin
                    state_d = ST_BYTE2;
                end
            end
            ST_BYTE2: begin
                if (byte_fire) begin
                    state_d = ST_COLLECT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_COLLECT;
        end else begin
            state_q <= state_d;
        end
    end

    // Pixel pairing; a row start discards any half pair
    always_ff @(posedge clk) begin
        if (rst) begin
            have_even_q <= 1'b0;
            even_q <= PIX_MIN;
            odd_q <= PIX_MIN;
            group_first_q <= 1'b0;
            group_last_q <= 1'b0;
        end else if (in_fire) begin
            if (pair_done) begin
                odd_q <= pix_in.value;
                have_even_q <= 1'b0;
                group_last_q <= pix_in.row_end;
            end else begin
                even_q <= pix_in.value;
                group_first_q <= row_begin || !row_open_q;
                if (pix_in.row_end) begin
                    odd_q <= PAD_PIX;
                    have_even_q <= 1'b0;
                    group_last_q <= 1'b1;
                end else begin
                    have_even_q <= 1'b1;
                end
            end
        end
    end

    // Row parity tracking: frame start resets to an even row
    always_ff @(posedge clk) begin
        if (rst) begin
            row_odd_q <= ROW_PAR_RST;
            row_open_q <= 1'b0;
        end else if (in_fire) begin
            if (pix_in.frame_start && pix_in.row_start) begin
                row_odd_q <= ROW_PAR_RST;
            end else if (row_begin && !row_open_q) begin
                row_odd_q <= !row_odd_q;
            end
            row_open_q <= !pix_in.row_end;
        end
    end

    // Sticky odd-length flag, a fresh frame clears it; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (lone_end) begin
            err_q <= 1'b1;
        end else if (in_fire && pix_in.frame_start) begin
            err_q <= 1'b0;
        end
    end

    assign odd_row_error = err_q;

    byte_fifo #(
        .WIDTH(BYTE_BEAT_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_raw),
        .out_valid(byte_valid),
        .out_ready(byte_ready)
    );

    assign byte_out = byte_beat_t'(fifo_out_raw);
endmodule // raw_color_12bit_packer

// File: raw_pack_pkg.sv
// Shared types and constants for the raw colour 12-bit packer
package raw_pack_pkg;
    localparam int unsigned PIX_W = 12;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned HI_MSB = 11;
    localparam int unsigned HI_LSB = 4;
    localparam int unsigned LO_MSB = 3;
    localparam logic [11:0] PIX_MIN = 12'h000;
    localparam logic [11:0] PIX_MAX = 12'hfff;
    localparam logic [11:0] PAD_PIX = 12'h000;
    localparam logic [1:0] GRP_RST = 2'h0;
    localparam logic ROW_PAR_RST = 1'b0;

    // Filter site colour of a pixel
    typedef enum logic [1:0] {
        SITE_BLUE = 2'b00,
        SITE_GREEN = 2'b01,
        SITE_RED = 2'b10
    } site_t;

    // One pixel beat from the sensor path
    typedef struct packed {
        logic [11:0] value;
        logic row_start;
        logic row_end;
        logic frame_start;
    } pix_beat_t;

    // One byte beat towards the image buffer
    typedef struct packed {
        logic [7:0] data;
        logic row_first;
        logic row_last;
        site_t site;
    } byte_beat_t;

    localparam int unsigned BYTE_BEAT_W = $bits(byte_beat_t);
endpackage

// File: byte_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointer arithmetic assumes a power-of-two depth
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("byte_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_q < (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // byte_fifo

// File: site_mapper.sv
// Maps row parity and pixel index parity to a filter site colour
`timescale 1ns/1ps
module site_mapper (
    input wire logic odd_row,
    input wire logic odd_pix,
    output raw_pack_pkg::site_t site
);
    import raw_pack_pkg::*;

    // Even rows blue/green, odd rows green/red
    assign site = odd_row ? (odd_pix ? SITE_RED : SITE_GREEN)
                          : (odd_pix ? SITE_GREEN : SITE_BLUE);
endmodule // site_mapper

// File: raw_pack_asserts.sv
// Port checker for the raw colour 12-bit packer
`timescale 1ns/1ps
module raw_pack_asserts (
    input wire logic clk,
    input wire logic rst,
    input raw_pack_pkg::pix_beat_t pix_in,
    input wire logic pix_valid,
    input wire logic pix_ready,
    input raw_pack_pkg::byte_beat_t byte_out,
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire logic odd_row_error
);
    import raw_pack_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Pixel accepted, and the pixel that closes a row
    sequence take_s; pix_valid && pix_ready; endsequence
    sequence close_s; take_s ##0 pix_in.row_end; endsequence
    chk_out_held: assert property (byte_valid && !byte_ready |=>
        byte_valid && $stable(byte_out)) else $error("byte not held");
    chk_pack_gap: assert property (close_s |=> !pix_ready [*3])
        else $error("pixel taken during packing");
    chk_first_lat: assert property (close_s ##0 !byte_valid |->
        ##2 byte_valid) else $error("first byte late");
    chk_err_clear: assert property (take_s ##0 (pix_in.frame_start &&
        pix_in.row_start && !pix_in.row_end) |=> !odd_row_error)
        else $error("error flag not cleared");
    chk_err_sticky: assert property (odd_row_error &&
        !(pix_valid && pix_ready && pix_in.frame_start) |=> odd_row_error)
        else $error("error flag lost");
    chk_edge_bytes: assert property (byte_valid && byte_out.row_first |->
        !byte_out.row_last) else $error("row shorter than a group");
    chk_first_site: assert property (byte_valid && byte_out.row_first |->
        byte_out.site != SITE_RED) else $error("bad first site");
    chk_last_site: assert property (byte_valid && byte_out.row_last |->
        byte_out.site != SITE_BLUE) else $error("bad last site");
endmodule // raw_pack_asserts

// File: byte_sink.sv
// Image buffer side byte sink with stall and hold modes
`timescale 1ns/1ps
module byte_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic hold,
    output logic byte_ready
);
    logic [7:0] lfsr_q;
    // Stall pattern; a busy host is never kinder than this
    always_ff @(posedge clk) begin
        if (rst) begin
            lfsr_q <= 8'h5a;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4]};
        end
    end
    // Hold lets the design's buffer fill up
    assign byte_ready = !hold && (!slow || lfsr_q[0]);
endmodule // byte_sink

// File: raw_color_12bit_packer_bench.sv
// Self-checking bench for the raw colour 12-bit packer
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module raw_color_12bit_packer_bench;
    import raw_pack_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pix_beat_t pix_in = '0;
    logic pix_valid = 1'b0;
    logic slow = 1'b0;
    logic hold = 1'b0;
    logic pix_ready, byte_valid, byte_ready, odd_row_error, row_par;
    byte_beat_t byte_out, e, want;
    byte_beat_t exp_q[$];
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'hbe946fa8;
    always #5 clk = ~clk;
    raw_color_12bit_packer #(.FIFO_WORDS(8)) dut_u (.clk(clk), .rst(rst),
        .pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready),
        .byte_out(byte_out), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .odd_row_error(odd_row_error));
    byte_sink sink_u (.clk(clk), .rst(rst), .slow(slow), .hold(hold),
        .byte_ready(byte_ready));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic site_t site_of(input logic odd);
        return odd ? (row_par ? SITE_RED : SITE_GREEN)
                   : (row_par ? SITE_GREEN : SITE_BLUE);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Handshake: hold the beat until pix_ready is seen at an edge
    task automatic put(input pix_beat_t b);
        int k;
        k = 0;
        pix_in <= b;
        pix_valid <= 1'b1;
        do begin @(posedge clk); k++; end
        while (pix_ready !== 1'b1 && k < 200);
        if (k >= 200) begin mismatches++; stop_test(); end
    endtask
    task automatic send_row(input int n, input logic fs, input logic corner);
        logic [11:0] v[16];
        int i;
        row_par = fs ? 1'b0 : ~row_par;
        for (i = 0; i < n; i++) begin
            seed = lfsr(seed);
            v[i] = corner ? (i[0] ? PIX_MIN : PIX_MAX) : seed[11:0];
        end
        for (i = 0; i < n; i += 2) begin
            e = '{v[i][11:4], i == 0, 1'b0, site_of(1'b0)};
            exp_q.push_back(e);
            e.data = {(i + 1 < n) ? v[i+1][3:0] : 4'h0, v[i][3:0]};
            e.row_first = 1'b0;
            e.site = site_of(1'b1);
            exp_q.push_back(e);
            e.data = (i + 1 < n) ? v[i+1][11:4] : 8'h00;
            e.row_last = (i + 2 >= n);
            exp_q.push_back(e);
        end
        for (i = 0; i < n; i++) put('{v[i], i == 0, i == n - 1, fs && i == 0});
    endtask
    task automatic drain(input int t);
        int k;
        k = 0;
        pix_valid <= 1'b0;
        while (exp_q.size() != 0 && k < 3000) begin @(posedge clk); k++; end
        if (k >= 3000) begin mismatches++; stop_test(); end
        $display("test %0d done", t);
    endtask
    // Byte scoreboard at each accepted byte
    always @(posedge clk) begin
        if (!rst && byte_valid === 1'b1 && byte_ready) begin
            `CHK(exp_q.size() != 0, 1'b1)
            if (exp_q.size() != 0) begin
                want = exp_q.pop_front();
                `CHK(byte_out, want)
            end
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        send_row(4, 1'b1, 1'b1);
        send_row(6, 1'b0, 1'b0);
        drain(1);
        `CHK(odd_row_error, 1'b0)
        send_row(3, 1'b0, 1'b0);
        drain(2);
        `CHK(odd_row_error, 1'b1)
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(odd_row_error, 1'b0)
        `CHK(byte_valid, 1'b0)
        `CHK(pix_ready, 1'b1)
        hold <= 1'b1;
        fork
            begin
                repeat (60) @(posedge clk);
                `CHK(pix_ready, 1'b0)
                hold <= 1'b0;
            end
        join_none
        send_row(16, 1'b1, 1'b0);
        drain(3);
        `CHK(odd_row_error, 1'b0)
        slow <= 1'b1;
        repeat (30) begin
            seed = lfsr(seed);
            send_row(2 + seed[3:0] % 15, seed[4], seed[5] & seed[6]);
        end
        drain(4);
        stop_test();
    end
endmodule // raw_color_12bit_packer_bench
bind raw_color_12bit_packer raw_pack_asserts chk_u (.clk(clk), .rst(rst),
    .pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .byte_out(byte_out), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .odd_row_error(odd_row_error));
